// ==== isp_byte_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides
module isp_byte_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_in,       // System clock
	input  wire logic             sys_rst_in,   // Synchronous reset, high
	input  wire logic             flush_in,     // Empties the FIFO
	input  wire logic             in_valid_in,  // Write request
	output logic                  in_ready_out, // Room for a word
	input  wire logic [WIDTH-1:0] in_data_in,   // Write data
	output logic                  out_valid_out,// Word available
	input  wire logic             out_ready_in, // Reader takes word
	output logic      [WIDTH-1:0] out_data_out  // Read data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_ff;
	logic [AW:0]      rd_ptr_ff;
	wire              full_w  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
	wire              empty_w = (wr_ptr_ff == rd_ptr_ff);
	wire              push_w  = in_valid_in && !full_w;
	wire              pop_w   = out_ready_in && !empty_w;

	assign in_ready_out  = !full_w;
	assign out_valid_out = !empty_w;
	assign out_data_out  = mem[rd_ptr_ff[AW-1:0]];

	always_ff @(posedge clk_in) begin
		if (push_w) begin
			mem[wr_ptr_ff[AW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in || flush_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push_w);
			rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop_w);
		end
	end

endmodule : isp_byte_fifo

// ==== isp_defines.svh ====
// Constants for the serial in-system programming port
`ifndef ISP_DEFINES_SVH
`define ISP_DEFINES_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS       25
`define FLASH_PAGE_WAIT_NS  14000000
`define EEPROM_BYTE_WAIT_NS 3400000
`define ERASE_WAIT_NS       28000000

// ****************************************************************
// Memory geometry
// ****************************************************************
`define FLASH_AW     13
`define FLASH_WORDS  14'h2000
`define EE_AW        9
`define EE_BYTES     14'h0200
`define PAGE_AW      6
`define PAGE_WORDS   14'h0040
`define SWEEP_W      14
`define TIMER_W      21
`define FIFO_DEPTH   32
`define ERASED_BYTE  8'hff
`define ERASED_WORD  16'hffff

// ****************************************************************
// Instruction encoding
// ****************************************************************
`define OP_ENABLE      8'hac
`define ENABLE_KEY     8'h53
`define ERASE_KEY      3'h4
`define OP_PAGE_WRITE  8'h4c
`define OP_LOAD_MASKED 7'h20
`define OP_READ_MASKED 7'h10
`define OP_EE_READ     8'ha0
`define OP_EE_WRITE    8'hc0
`define HALF_BIT       3
`define LAST_BIT       3'h7
`define LAST_POS       2'h3

`endif

// ==== isp_pkg.sv ====
// Types shared by the serial in-system programming port
package isp_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ERASE,
		ST_FLASH,
		ST_EEPROM
	} eng_state_e;

endpackage : isp_pkg

// ==== isp_programmer_model.sv ====
// Behavioural serial programmer that drives the link of the programming port
module isp_programmer_model #(
	parameter int SETTLE_CYC = 40  // Shortened power-up settle time, in system clocks
) (
	input  wire logic clk_in,        // System clock, times the reset pulse
	input  wire logic miso_in,       // Serial data from the device
	input  wire logic miso_oe_in,    // Device drives its serial output
	output logic      sck_out,       // Serial clock
	output logic      mosi_out,      // Serial data to the device
	output logic      rst_pin_n_out  // Reset pin, low while programming
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam int HALF_NS = 100;

	logic last_bit;
	wire logic line_level;

	// An undriven line shows the inverse of its last value
	assign line_level = miso_oe_in ? miso_in : ~last_bit;

	initial begin
		sck_out = 1'b0;
		mosi_out = 1'b0;
		rst_pin_n_out = 1'b0;
		last_bit = 1'b0;
	end

	task automatic pulse_reset();
		rst_pin_n_out = 1'b1;
		repeat (4) @(posedge clk_in);
		#2 rst_pin_n_out = 1'b0;
		repeat (SETTLE_CYC) @(posedge clk_in);
		#2;
	endtask : pulse_reset

	task automatic set_pin(input logic level);
		rst_pin_n_out = level;
		repeat (8) @(posedge clk_in);
		#2;
	endtask : set_pin

	// Always four whole bytes, full duplex
	task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp);
		for (int i = 31; i >= 0; i--) begin
			mosi_out = cmd[i];
			#HALF_NS sck_out = 1'b1;
			#(HALF_NS - 1) resp[i] = line_level;
			last_bit = line_level;
			#1 sck_out = 1'b0;
		end
	endtask : xfer
endmodule : isp_programmer_model

// ==== isp_serial_port.sv ====
// Serial in-system programming port: shifter, instruction engine and arrays
`include "isp_defines.svh"

module isp_serial_port #(
	parameter int unsigned FLASH_WAIT_CYC = `FLASH_PAGE_WAIT_NS / `CLK_PERIOD_NS,
	parameter int unsigned EE_WAIT_CYC    = `EEPROM_BYTE_WAIT_NS / `CLK_PERIOD_NS,
	parameter int unsigned ERASE_WAIT_CYC = `ERASE_WAIT_NS / `CLK_PERIOD_NS,
	parameter int          FIFO_DEPTH     = `FIFO_DEPTH
) (
	input  wire logic clk_in,            // System clock input, 40 MHz
	input  wire logic sys_rst_in,        // Synchronous reset, high
	input  wire logic rst_pin_n_in,      // External reset pin, low = programming
	input  wire logic sck_in,            // Serial clock from programmer
	input  wire logic mosi_in,           // Serial data in
	output logic      miso_out,          // Serial data out
	output logic      miso_oe_out,       // Drive enable for serial data out
	output logic      prog_enabled_out,  // Enable instruction accepted
	output logic      busy_out,          // Self-timed operation running
	output logic      overrun_out        // A received byte found the FIFO full
);

	// ****************************************************************
	// Pin synchronisers and edge detection
	// ****************************************************************
	logic sck_s1_ff, sck_s2_ff, sck_d_ff;
	logic mosi_s1_ff, mosi_s2_ff;
	logic rstp_s1_ff, rstp_s2_ff;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sck_s1_ff  <= 1'b0;
			sck_s2_ff  <= 1'b0;
			sck_d_ff   <= 1'b0;
			mosi_s1_ff <= 1'b0;
			mosi_s2_ff <= 1'b0;
			rstp_s1_ff <= 1'b1;
			rstp_s2_ff <= 1'b1;
		end else begin
			sck_s1_ff  <= sck_in;
			sck_s2_ff  <= sck_s1_ff;
			sck_d_ff   <= sck_s2_ff;
			mosi_s1_ff <= mosi_in;
			mosi_s2_ff <= mosi_s1_ff;
			rstp_s1_ff <= rst_pin_n_in;
			rstp_s2_ff <= rstp_s1_ff;
		end
	end

	wire prog_w     = !rstp_s2_ff;
	wire sck_rise_w = prog_w && sck_s2_ff && !sck_d_ff;
	wire sck_fall_w = prog_w && !sck_s2_ff && sck_d_ff;

	// ****************************************************************
	// Byte shifter
	// ****************************************************************
	logic [2:0] bit_cnt_ff;
	logic [1:0] pos_ff;
	logic [7:0] rx_ff;
	logic [7:0] tx_ff;
	logic [7:0] b0_ff, b1_ff, b2_ff;
	logic       miso_ff, miso_oe_ff, overrun_ff;

	wire [7:0] nxt_rx    = {rx_ff[6:0], mosi_s2_ff};
	wire       byte_done = sck_rise_w && (bit_cnt_ff == `LAST_BIT);
	wire       fifo_in_ready;

	// ****************************************************************
	// Memories and engine state, declared early for the read path
	// ****************************************************************
	logic [15:0]             flash_mem [1 << `FLASH_AW];
	logic [7:0]              ee_mem    [1 << `EE_AW];
	logic [7:0]              pb_lo     [1 << `PAGE_AW];
	logic [7:0]              pb_hi     [1 << `PAGE_AW];
	isp_pkg::eng_state_e     state_ff, nxt_state;
	logic [`FLASH_AW-`PAGE_AW-1:0] busy_page_ff;
	logic [`EE_AW-1:0]       busy_ee_ff;
	logic                    enabled_ff, busy_ff;

	// ****************************************************************
	// Read path, answered straight from the arrays
	// ****************************************************************
	wire [`FLASH_AW-1:0] fl_raddr   = {b1_ff[4:0], b2_ff};
	wire [`EE_AW-1:0]    ee_raddr   = {b1_ff[0], b2_ff};
	wire [15:0]          fl_word    = flash_mem[fl_raddr];
	wire [7:0]           fl_byte    = b0_ff[`HALF_BIT] ? fl_word[15:8] : fl_word[7:0];
	wire                 is_fl_read = ({b0_ff[7:4], b0_ff[2:0]} == `OP_READ_MASKED);
	wire                 is_ee_read = (b0_ff == `OP_EE_READ);
	wire                 fl_hit     = (state_ff == isp_pkg::ST_ERASE)
	                               || (state_ff == isp_pkg::ST_FLASH
	                                   && fl_raddr[`FLASH_AW-1:`PAGE_AW] == busy_page_ff);
	wire                 ee_hit     = (state_ff == isp_pkg::ST_ERASE)
	                               || (state_ff == isp_pkg::ST_EEPROM && ee_raddr == busy_ee_ff);
	wire [7:0]           fl_rdata   = fl_hit ? `ERASED_BYTE : fl_byte;
	wire [7:0]           ee_rdata   = ee_hit ? `ERASED_BYTE : ee_mem[ee_raddr];
	wire [7:0]           rd_data    = !enabled_ff ? b2_ff
	                               : is_fl_read ? fl_rdata
	                               : is_ee_read ? ee_rdata : b2_ff;
	wire [7:0]           resp       = (pos_ff == 2'h0) ? 8'h00
	                               : (pos_ff == 2'h1) ? b0_ff
	                               : (pos_ff == 2'h2) ? b1_ff : rd_data;
	wire                 load_tx    = sck_fall_w && (bit_cnt_ff == 3'h0);
	wire [7:0]           nxt_tx     = !prog_w ? 8'h00
	                               : load_tx ? resp
	                               : sck_fall_w ? {tx_ff[6:0], 1'b0} : tx_ff;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !prog_w) begin
			bit_cnt_ff <= 3'h0;
			pos_ff     <= 2'h0;
			rx_ff      <= 8'h00;
			b0_ff      <= 8'h00;
			b1_ff      <= 8'h00;
			b2_ff      <= 8'h00;
			overrun_ff <= 1'b0;
		end else begin
			if (sck_rise_w) begin
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
				rx_ff      <= nxt_rx;
			end
			if (byte_done) begin
				pos_ff <= pos_ff + 2'h1;
				if (pos_ff == 2'h0) b0_ff <= nxt_rx;
				if (pos_ff == 2'h1) b1_ff <= nxt_rx;
				if (pos_ff == 2'h2) b2_ff <= nxt_rx;
				if (!fifo_in_ready) overrun_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			tx_ff      <= 8'h00;
			miso_ff    <= 1'b0;
			miso_oe_ff <= 1'b0;
		end else begin
			tx_ff      <= nxt_tx;
			miso_ff    <= nxt_tx[7];
			miso_oe_ff <= prog_w;
		end
	end

	// ****************************************************************
	// Received byte FIFO
	// ****************************************************************
	wire       fifo_out_valid;
	wire [9:0] fifo_out_data;
	wire       sweeping;
	wire       eng_ready = !sweeping;

	isp_byte_fifo #(
		.WIDTH (10),
		.DEPTH (FIFO_DEPTH)
	) isp_byte_fifo_i (
		.clk_in        (clk_in),
		.sys_rst_in    (sys_rst_in),
		.flush_in      (!prog_w),
		.in_valid_in   (byte_done),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    ({pos_ff, nxt_rx}),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (eng_ready),
		.out_data_out  (fifo_out_data)
	);

	// ****************************************************************
	// Instruction engine
	// ****************************************************************
	logic [7:0]          e0_ff, e1_ff, e2_ff;
	logic [`SWEEP_W-1:0] sweep_ff;
	logic [`TIMER_W-1:0] timer_ff;

	wire       pop      = fifo_out_valid && eng_ready;
	wire [1:0] in_pos   = fifo_out_data[9:8];
	wire [7:0] in_byte  = fifo_out_data[7:0];
	wire       exec     = pop && (in_pos == `LAST_POS);
	wire       idle     = (state_ff == isp_pkg::ST_IDLE);

	wire dec_enable  = (e0_ff == `OP_ENABLE) && (e1_ff == `ENABLE_KEY);
	wire dec_erase   = (e0_ff == `OP_ENABLE) && (e1_ff[7:5] == `ERASE_KEY);
	wire dec_load    = ({e0_ff[7:4], e0_ff[2:0]} == `OP_LOAD_MASKED);
	wire dec_pwrite  = (e0_ff == `OP_PAGE_WRITE);
	wire dec_eewrite = (e0_ff == `OP_EE_WRITE);

	wire go_enable  = exec && dec_enable;
	wire go_erase   = exec && idle && enabled_ff && dec_erase;
	wire go_load    = exec && enabled_ff && dec_load;
	wire go_pwrite  = exec && idle && enabled_ff && dec_pwrite;
	wire go_eewrite = exec && idle && enabled_ff && dec_eewrite;

	wire in_erase = (state_ff == isp_pkg::ST_ERASE);
	wire in_flash = (state_ff == isp_pkg::ST_FLASH);
	assign sweeping = (in_erase && sweep_ff < `FLASH_WORDS) || (in_flash && sweep_ff < `PAGE_WORDS);
	wire op_done    = !idle && (timer_ff == '0) && !sweeping;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			isp_pkg::ST_IDLE: begin
				if (go_erase) nxt_state = isp_pkg::ST_ERASE;
				else if (go_pwrite) nxt_state = isp_pkg::ST_FLASH;
				else if (go_eewrite) nxt_state = isp_pkg::ST_EEPROM;
			end
			isp_pkg::ST_ERASE, isp_pkg::ST_FLASH, isp_pkg::ST_EEPROM: begin
				if (op_done) nxt_state = isp_pkg::ST_IDLE;
			end
			default: nxt_state = isp_pkg::ST_IDLE;
		endcase
	end

	wire [`TIMER_W-1:0] load_time = go_erase ? `TIMER_W'(ERASE_WAIT_CYC)
	                              : go_pwrite ? `TIMER_W'(FLASH_WAIT_CYC) : `TIMER_W'(EE_WAIT_CYC);

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_ff     <= isp_pkg::ST_IDLE;
			timer_ff     <= '0;
			sweep_ff     <= '0;
			busy_page_ff <= '0;
			busy_ee_ff   <= '0;
			busy_ff      <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			busy_ff  <= (nxt_state != isp_pkg::ST_IDLE);
			if (idle && nxt_state != isp_pkg::ST_IDLE) begin
				timer_ff <= load_time;
				sweep_ff <= '0;
			end else begin
				if (timer_ff != '0) timer_ff <= timer_ff - `TIMER_W'(1);
				if (sweeping) sweep_ff <= sweep_ff + `SWEEP_W'(1);
			end
			if (go_pwrite) busy_page_ff <= {e1_ff[4:0], e2_ff[7:6]};
			if (go_eewrite) busy_ee_ff <= {e1_ff[0], e2_ff};
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !prog_w) begin
			e0_ff      <= 8'h00;
			e1_ff      <= 8'h00;
			e2_ff      <= 8'h00;
			enabled_ff <= 1'b0;
		end else begin
			if (pop && in_pos == 2'h0) e0_ff <= in_byte;
			if (pop && in_pos == 2'h1) e1_ff <= in_byte;
			if (pop && in_pos == 2'h2) e2_ff <= in_byte;
			if (go_enable) enabled_ff <= 1'b1;
		end
	end

	// ****************************************************************
	// Array writes
	// ****************************************************************
	wire                 fl_we = sweeping;
	wire [`FLASH_AW-1:0] fl_wa = in_erase ? sweep_ff[`FLASH_AW-1:0]
	                           : {busy_page_ff, sweep_ff[`PAGE_AW-1:0]};
	wire [15:0]          fl_wd = in_erase ? `ERASED_WORD
	                           : {pb_hi[sweep_ff[`PAGE_AW-1:0]], pb_lo[sweep_ff[`PAGE_AW-1:0]]};
	wire                 ee_we = (in_erase && sweep_ff < `EE_BYTES) || go_eewrite;
	wire [`EE_AW-1:0]    ee_wa = in_erase ? sweep_ff[`EE_AW-1:0] : {e1_ff[0], e2_ff};
	wire [7:0]           ee_wd = in_erase ? `ERASED_BYTE : in_byte;

	always_ff @(posedge clk_in) begin
		if (fl_we) flash_mem[fl_wa] <= fl_wd;
		if (ee_we) ee_mem[ee_wa] <= ee_wd;
		if (go_load && !e0_ff[`HALF_BIT]) pb_lo[e2_ff[`PAGE_AW-1:0]] <= in_byte;
		if (go_load && e0_ff[`HALF_BIT]) pb_hi[e2_ff[`PAGE_AW-1:0]] <= in_byte;
	end

	assign miso_out         = miso_ff;
	assign miso_oe_out      = miso_oe_ff;
	assign prog_enabled_out = enabled_ff;
	assign busy_out         = busy_ff;
	assign overrun_out      = overrun_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_erase_start;
		idle && go_erase;
	endsequence

	sequence s_erase_fill;
		(fl_we && fl_wd == `ERASED_WORD && ee_we && ee_wd == `ERASED_BYTE)[*8];
	endsequence

	a_prog_window: assert property (!prog_w |=> !enabled_ff && !miso_oe_out)
		else $error("programming state survived reset pin high");

	a_enable_first: assert property (exec && !enabled_ff && !dec_enable |=> idle && !enabled_ff)
		else $error("instruction acted before enable");

	a_erase_fill: assert property (s_erase_start |=> s_erase_fill)
		else $error("chip erase did not write ones");

	a_ee_autoerase: assert property (go_eewrite |=> state_ff == isp_pkg::ST_EEPROM ##0 ee_mem[busy_ee_ff] == $past(in_byte))
		else $error("EEPROM write needed prior erase");

	a_rise_sample: assert property (sck_rise_w |=> rx_ff[0] == $past(mosi_s2_ff))
		else $error("data not sampled on rising clock");

	a_fall_shift: assert property (sck_fall_w && bit_cnt_ff != 3'h0 |=> tx_ff == {$past(tx_ff[6:0]), 1'b0})
		else $error("data not shifted on falling clock");

	a_echo_key: assert property (load_tx && pos_ff == 2'h2 && b1_ff == `ENABLE_KEY |=> tx_ff == `ENABLE_KEY && miso_out == tx_ff[7])
		else $error("enable key not echoed");

	a_flash_poll: assert property (load_tx && pos_ff == `LAST_POS && enabled_ff && is_fl_read && fl_hit |=> tx_ff == `ERASED_BYTE)
		else $error("flash page under write not read as ones");

	a_ee_poll: assert property (load_tx && pos_ff == `LAST_POS && enabled_ff && is_ee_read && ee_hit |=> tx_ff == `ERASED_BYTE)
		else $error("EEPROM byte under write not read as ones");

	a_read_data: assert property (load_tx && pos_ff == `LAST_POS && enabled_ff && is_fl_read && !fl_hit |=> tx_ff == $past(fl_byte))
		else $error("flash read returned wrong data");

	a_page_addr: assert property (go_pwrite |=> busy_page_ff == {$past(e1_ff[4:0]), $past(e2_ff[7:6])} ##1 fl_we)
		else $error("page write address or commit wrong");

endmodule : isp_serial_port

// ==== tb_isp_serial_port.sv ====
// Self-checking testbench for the serial programming port
module tb_isp_serial_port;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned FLASH_CYC = 600;
	localparam int unsigned EE_CYC    = 600;
	localparam int unsigned ERASE_CYC = 9000;
	localparam int          LIMIT     = 60000;

	logic        clk_in;
	logic        sys_rst_in;
	logic        rst_pin_n;
	logic        sck;
	logic        mosi;
	logic        miso;
	logic        miso_oe;
	logic        prog_en;
	logic        busy;
	logic        overrun;
	logic [31:0] resp;
	int          fail_count = 0;
	int          num_checks = 0;
	int          cycles = 0;
	int          busy_run = 0;
	int          busy_len = 0;

	isp_serial_port #(.FLASH_WAIT_CYC(FLASH_CYC), .EE_WAIT_CYC(EE_CYC), .ERASE_WAIT_CYC(ERASE_CYC),
		.FIFO_DEPTH(32)) isp_serial_port_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.rst_pin_n_in(rst_pin_n), .sck_in(sck), .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe),
		.prog_enabled_out(prog_en), .busy_out(busy), .overrun_out(overrun));

	isp_programmer_model isp_programmer_model_i (.clk_in(clk_in), .miso_in(miso), .miso_oe_in(miso_oe),
		.sck_out(sck), .mosi_out(mosi), .rst_pin_n_out(rst_pin_n));

	// ****************************************************************
	// Clock, timeout and busy length monitor
	// ****************************************************************
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fail_count++;
			give_verdict();
		end
	end

	always @(posedge clk_in) begin
		if (busy === 1'b1) begin
			busy_run <= busy_run + 1;
		end else if (busy_run != 0) begin
			busy_len <= busy_run;
			busy_run <= 0;
		end
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chkb(input string what, input logic exp, input logic got);
		chk(what, {15'h0000, exp}, {15'h0000, got});
	endtask : chkb

	task automatic send(input logic [31:0] cmd);
		isp_programmer_model_i.xfer(cmd, resp);
		repeat (8) @(posedge clk_in);
		#2;
	endtask : send

	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 20000) begin
			@(posedge clk_in);
			#2;
			n++;
		end
		@(posedge clk_in);
		#2;
		chkb("busy cleared", 1'b0, busy);
	endtask : wait_idle

	task automatic enable();
		send(32'hac530000);
		chk("enable echo", 16'hac53, resp[23:8]);
		chkb("enabled", 1'b1, prog_en);
	endtask : enable

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_refused();
		chkb("miso drive", 1'b1, miso_oe);
		send(32'hc0001077);
		chkb("write before enable", 1'b0, busy);
		send(32'hac800000);
		chk("byte echo", 16'h00ac, resp[31:16]);
		chkb("erase before enable", 1'b0, busy);
	endtask : t_refused

	task automatic t_bad_echo();
		send(32'hac000000);
		chk("wrong echo", 16'h0000, {8'h00, resp[15:8]});
		chkb("not enabled", 1'b0, prog_en);
		isp_programmer_model_i.pulse_reset();
		enable();
	endtask : t_bad_echo

	task automatic t_erase();
		send(32'hac800000);
		chkb("erase busy", 1'b1, busy);
		for (int i = 0; i < 10; i++) begin
			send(32'ha001ff00);
			if (i == 0) chk("poll in erase", 16'h00ff, {8'h00, resp[7:0]});
		end
		chkb("fifo overrun", 1'b1, overrun);
		wait_idle();
		// Busy spans the loaded count plus the cycle that sees it run out
		chk("erase time", 16'(ERASE_CYC + 1), busy_len[15:0]);
		isp_programmer_model_i.pulse_reset();
		chkb("overrun cleared", 1'b0, overrun);
		enable();
		send(32'h281fff00);
		chk("flash top erased", 16'h00ff, {8'h00, resp[7:0]});
		send(32'h20000000);
		chk("flash base erased", 16'h00ff, {8'h00, resp[7:0]});
		send(32'ha001ff00);
		chk("eeprom top erased", 16'h00ff, {8'h00, resp[7:0]});
	endtask : t_erase

	task automatic t_eeprom();
		send(32'hc001ffa5);
		chkb("eeprom busy", 1'b1, busy);
		send(32'ha001ff00);
		chk("eeprom poll", 16'h00ff, {8'h00, resp[7:0]});
		wait_idle();
		chk("eeprom time", 16'(EE_CYC + 1), busy_len[15:0]);
		send(32'ha001ff00);
		chk("eeprom read", 16'h00a5, {8'h00, resp[7:0]});
		send(32'hc001ff3c);
		wait_idle();
		send(32'ha001ff00);
		chk("eeprom rewrite", 16'h003c, {8'h00, resp[7:0]});
	endtask : t_eeprom

	task automatic t_flash();
		send(32'h40000534);
		send(32'h48000512);
		send(32'h4c1fc000);
		chkb("page busy", 1'b1, busy);
		send(32'h201fc500);
		chk("page poll", 16'h00ff, {8'h00, resp[7:0]});
		wait_idle();
		chk("page time", 16'(FLASH_CYC + 1), busy_len[15:0]);
		send(32'h201fc500);
		chk("flash low byte", 16'h0034, {8'h00, resp[7:0]});
		send(32'h281fc500);
		chk("flash high byte", 16'h0012, {8'h00, resp[7:0]});
		send(32'h20000500);
		chk("other page", 16'h00ff, {8'h00, resp[7:0]});
		send(32'ha001c500);
		chk("eeprom untouched", 16'h00ff, {8'h00, resp[7:0]});
	endtask : t_flash

	task automatic t_release();
		isp_programmer_model_i.set_pin(1'b1);
		chkb("enable dropped", 1'b0, prog_en);
		chkb("miso released", 1'b0, miso_oe);
		isp_programmer_model_i.set_pin(1'b0);
		send(32'hc0000042);
		chkb("write after release", 1'b0, busy);
	endtask : t_release

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		sys_rst_in = 1'b1;
		repeat (4) @(posedge clk_in);
		#2 sys_rst_in = 1'b0;
		repeat (4) @(posedge clk_in);
		#2;
		t_refused();
		t_bad_echo();
		t_erase();
		t_eeprom();
		t_flash();
		t_release();
		give_verdict();
	end
endmodule : tb_isp_serial_port
